// file: vbadt_top.sv
// Purpose: VBUS debouncing, USB regulator gating and attach protocol engine
// Assumes: Comparator inputs synchronous; i_xtal_tick is a 32.768 kHz enable pulse
// Notes:   Level debounce is restart-on-change; outputs are registered
`default_nettype none
module vbadt_deb #(
  parameter int unsigned CYC = 3000
) (
  input  wire logic i_sys_clk,
  input  wire logic i_reset,
  input  wire logic i_in,
  output logic      o_out
);
  localparam int unsigned W = $clog2(CYC + 1);
  logic [W-1:0] cnt_q, cnt_d;
  logic         out_q, out_d;
  always_comb
  begin
    cnt_d = cnt_q;
    out_d = out_q;
    if (i_in == out_q)
      cnt_d = '0;
    else if (cnt_q == W'(CYC - 1))
    begin
      out_d = i_in;
      cnt_d = '0;
    end
    else
      cnt_d = cnt_q + W'(1);
  end
  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      cnt_q <= '0;
      out_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end
  assign o_out = out_q;
endmodule : vbadt_deb

module vbadt_top
  import vbadt_pkg::*;
#(
  parameter int unsigned LVL_CYC = LVL_DEB_CYC,
  parameter int unsigned ADP_CYC = ADP_DEB_CYC,
  parameter int unsigned SNS_TKS = SNS_TIMEOUT_TKS,
  parameter int unsigned PER_TKS = PROBE_PER_TKS
) (
  // Clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset,
  input  wire logic       i_xtal_tick,
  // Analog comparator inputs
  input  wire logic       i_vbus_wakeup_cmp,
  input  wire vbadt_pkg::vbadt_lvl_t i_lvl,
  input  wire logic       i_probing_comparator,
  input  wire logic       i_sensing_comparator,
  input  wire logic       i_vbus_overvoltage,
  // Power and host control
  input  wire logic       i_precharge,
  input  wire logic       i_power_on_reset_out,
  input  wire logic       i_system_on,
  input  wire logic       i_regulator_auto_control_disable,
  input  wire logic       i_usb_regulator_state_reg_wr,
  input  wire logic       i_usb_regulator_state_reg_en,
  input  wire logic       i_wakeup_mask,
  input  wire vbadt_pkg::vbadt_cfg_t i_cfg,
  // Outputs
  output logic            o_usb_regulator_en,
  output logic            o_charger_mid_node_switch_closed,
  output logic            o_wakeup_irq,
  output vbadt_pkg::vbadt_lvl_t o_lvl_deb,
  output vbadt_pkg::vbadt_lvl_t o_lvl_irq,
  output logic            o_probe_current_sink_en,
  output logic            o_probe_current_source_en,
  output logic [7:0]      o_measured_rise_time,
  output logic [7:0]      o_rise_time_low_limit,
  output logic [7:0]      o_rise_time_high_limit,
  output logic            o_attach_irq
);
  import vbadt_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_SINK, ST_CHARGE, ST_WAIT} vbadt_st_t;

  localparam int unsigned TW = 12;

  logic [NUM_LVL-1:0] lvl_deb;
  logic prb_s1, prb_s2, sns_s1, sns_s2;

  // Level flag debounce
  genvar g;
  generate
    for (g = 0; g < NUM_LVL; g++)
    begin : g_lvl
      vbadt_deb #(.CYC(LVL_CYC)) u_deb (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .i_in      (i_lvl[g]),
        .o_out     (lvl_deb[g])
      );
    end
  endgenerate

  // Two-stage attach comparator debounce
  vbadt_deb #(.CYC(ADP_CYC)) u_prb1 (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
    .i_in(i_probing_comparator), .o_out(prb_s1));
  vbadt_deb #(.CYC(ADP_CYC)) u_prb2 (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
    .i_in(prb_s1), .o_out(prb_s2));
  vbadt_deb #(.CYC(ADP_CYC)) u_sns1 (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
    .i_in(i_sensing_comparator), .o_out(sns_s1));
  vbadt_deb #(.CYC(ADP_CYC)) u_sns2 (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
    .i_in(sns_s1), .o_out(sns_s2));

  // Regulator and power state
  logic reg_en_q, reg_en_d, auto_q, auto_d, wake_q, wake_d;
  logic sw_q, sw_d, wirq_q, wirq_d;
  logic [NUM_LVL-1:0] ldeb_q, ldeb_d, lirq_q, lirq_d;

  always_comb
  begin
    auto_d   = auto_q;
    reg_en_d = reg_en_q;
    wake_d   = i_vbus_wakeup_cmp;
    if (i_usb_regulator_state_reg_wr)
    begin
      auto_d   = 1'b0;
      reg_en_d = i_usb_regulator_state_reg_en;
    end
    else if (auto_q && !i_regulator_auto_control_disable)
      reg_en_d = i_vbus_wakeup_cmp;
    else if (!i_power_on_reset_out && i_precharge && i_vbus_wakeup_cmp)
      reg_en_d = 1'b1;
    else if (!i_system_on && i_vbus_wakeup_cmp)
      reg_en_d = reg_en_q;
    sw_d   = !i_vbus_overvoltage;
    wirq_d = (wake_d != wake_q) && !i_wakeup_mask;
    ldeb_d = lvl_deb;
    lirq_d = ldeb_q ^ lvl_deb;
  end

  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      auto_q   <= 1'b1;
      reg_en_q <= 1'b0;
      wake_q   <= 1'b0;
      sw_q     <= 1'b0;
      wirq_q   <= 1'b0;
      ldeb_q   <= '0;
      lirq_q   <= '0;
    end
    else
    begin
      auto_q   <= auto_d;
      reg_en_q <= reg_en_d;
      wake_q   <= wake_d;
      sw_q     <= sw_d;
      wirq_q   <= wirq_d;
      ldeb_q   <= ldeb_d;
      lirq_q   <= lirq_d;
    end
  end

  // Attach protocol engine
  vbadt_st_t  st_q, st_d;
  logic [TW-1:0] tmr_q, tmr_d;
  logic [7:0] cnt_q, cnt_d, rise_q, rise_d, lo_q, lo_d, hi_q, hi_d;
  logic       snk_q, snk_d, src_q, src_d, airq_q, airq_d, sns_prev_q;
  logic       probing;

  assign probing = i_cfg.attach_protocol_mode[1];

  always_comb
  begin
    st_d   = st_q;
    tmr_d  = tmr_q;
    cnt_d  = cnt_q;
    rise_d = rise_q;
    lo_d   = i_cfg.rise_time_low_limit;
    hi_d   = i_cfg.rise_time_high_limit;
    snk_d  = 1'b0;
    src_d  = src_q;
    airq_d = 1'b0;
    if (i_cfg.attach_protocol_mode == VBADT_MODE_OFF)
    begin
      st_d   = ST_IDLE;
      tmr_d  = '0;
      cnt_d  = LIMIT_RST;
      rise_d = LIMIT_RST;
      lo_d   = LIMIT_RST;
      hi_d   = LIMIT_RST;
      src_d  = 1'b0;
    end
    else if (!probing)
    begin
      st_d  = ST_IDLE;
      src_d = 1'b0;
      if ((sns_s2 && !sns_prev_q) || st_q != ST_IDLE)
        tmr_d = '0;
      else if (i_xtal_tick)
      begin
        if (tmr_q == TW'(SNS_TKS - 1))
        begin
          airq_d = 1'b1;
          tmr_d  = '0;
        end
        else
          tmr_d = tmr_q + TW'(1);
      end
    end
    else
    begin
      case (st_q)
        ST_IDLE:
        begin
          st_d  = ST_SINK;
          tmr_d = '0;
          cnt_d = '0;
          src_d = 1'b0;
        end
        ST_SINK:
        begin
          snk_d = 1'b1;
          if (i_xtal_tick)
          begin
            if (tmr_q == TW'(SINK_TICKS - 1))
            begin
              st_d  = ST_CHARGE;
              snk_d = 1'b0;
              src_d = 1'b1;
            end
            tmr_d = tmr_q + TW'(1);
          end
        end
        ST_CHARGE:
        begin
          if (prb_s2 || cnt_q == CNT_MAX)
          begin
            st_d   = ST_WAIT;
            src_d  = !prb_s2 && src_q;
            rise_d = cnt_q;
            airq_d = (cnt_q < lo_q) || (cnt_q > hi_q);
          end
          else if (i_xtal_tick)
            cnt_d = cnt_q + 8'h01;
          if (i_xtal_tick)
            tmr_d = tmr_q + TW'(1);
        end
        default:
        begin
          if (prb_s2)
            src_d = 1'b0;
          if (i_xtal_tick)
          begin
            if (tmr_q >= TW'(PER_TKS - 1))
              st_d = ST_IDLE;
            tmr_d = tmr_q + TW'(1);
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      st_q       <= ST_IDLE;
      tmr_q      <= '0;
      cnt_q      <= '0;
      rise_q     <= LIMIT_RST;
      lo_q       <= LIMIT_RST;
      hi_q       <= LIMIT_RST;
      snk_q      <= 1'b0;
      src_q      <= 1'b0;
      airq_q     <= 1'b0;
      sns_prev_q <= 1'b0;
    end
    else
    begin
      st_q       <= st_d;
      tmr_q      <= tmr_d;
      cnt_q      <= cnt_d;
      rise_q     <= rise_d;
      lo_q       <= lo_d;
      hi_q       <= hi_d;
      snk_q      <= snk_d;
      src_q      <= src_d;
      airq_q     <= airq_d;
      sns_prev_q <= sns_s2;
    end
  end

  assign o_usb_regulator_en               = reg_en_q;
  assign o_charger_mid_node_switch_closed = sw_q;
  assign o_wakeup_irq                     = wirq_q;
  assign o_lvl_deb                        = ldeb_q;
  assign o_lvl_irq                        = lirq_q;
  assign o_probe_current_sink_en          = snk_q;
  assign o_probe_current_source_en        = src_q;
  assign o_measured_rise_time             = rise_q;
  assign o_rise_time_low_limit            = lo_q;
  assign o_rise_time_high_limit           = hi_q;
  assign o_attach_irq                     = airq_q;

  // Checks
  property p_off_clears;
    @(posedge i_sys_clk) disable iff (i_reset)
    (i_cfg.attach_protocol_mode == VBADT_MODE_OFF) |=> (rise_q == 8'h00 && lo_q == 8'h00);
  endproperty
  a_off_clears: assert property (p_off_clears) else $error("fields not cleared");
  property p_no_overlap;
    @(posedge i_sys_clk) disable iff (i_reset) !(snk_q && src_q);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("sink and source both on");
  property p_sat;
    @(posedge i_sys_clk) disable iff (i_reset) (st_q == ST_CHARGE && cnt_q == CNT_MAX)
      |=> (rise_q == CNT_MAX);
  endproperty
  a_sat: assert property (p_sat) else $error("count not held at max");
  property p_ovp;
    @(posedge i_sys_clk) disable iff (i_reset) i_vbus_overvoltage |=> !sw_q;
  endproperty
  a_ovp: assert property (p_ovp) else $error("switch not opened");
  property p_mask;
    @(posedge i_sys_clk) disable iff (i_reset) i_wakeup_mask |=> !wirq_q;
  endproperty
  a_mask: assert property (p_mask) else $error("masked wake event");
  property p_src_stop;
    @(posedge i_sys_clk) disable iff (i_reset) (st_q == ST_CHARGE && prb_s2) |=> !src_q;
  endproperty
  a_src_stop: assert property (p_src_stop) else $error("source left on");
  property p_wr;
    @(posedge i_sys_clk) disable iff (i_reset) i_usb_regulator_state_reg_wr
      |=> (reg_en_q == $past(i_usb_regulator_state_reg_en));
  endproperty
  a_wr: assert property (p_wr) else $error("write did not set regulator");
  property p_lim;
    @(posedge i_sys_clk) disable iff (i_reset) (st_q == ST_CHARGE && prb_s2 && cnt_q < lo_q)
      |=> o_attach_irq;
  endproperty
  a_lim: assert property (p_lim) else $error("limit interrupt missing");
  c_probe: cover property (@(posedge i_sys_clk) st_q == ST_CHARGE ##1 st_q == ST_WAIT);
  c_sense: cover property (@(posedge i_sys_clk) !probing && airq_q);
  c_sat:   cover property (@(posedge i_sys_clk) cnt_q == CNT_MAX);
endmodule : vbadt_top
`default_nettype wire

// file: vbadt_pkg.sv
// Purpose: Constants and types for the VBUS attach detect timer block
// Assumes: 100 MHz system clock, 32.768 kHz tick supplied as an enable
// Notes:   Shared by the design and its bench
`default_nettype none
package vbadt_pkg;
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned LVL_DEB_MS      = 30;
  localparam int unsigned LVL_DEB_CYC     = (CLK_HZ / 1000) * LVL_DEB_MS;
  localparam int unsigned ADP_DEB_US      = 30;
  localparam int unsigned ADP_DEB_CYC     = (CLK_HZ / 1_000_000) * ADP_DEB_US;
  localparam int unsigned NUM_LVL         = 5;
  localparam logic [7:0]  CNT_MAX         = 8'hFF;
  localparam logic [7:0]  LIMIT_RST       = 8'h00;
  localparam int unsigned SINK_TICKS      = 16;
  localparam int unsigned SNS_TIMEOUT_TKS = 2048;
  localparam int unsigned PROBE_PER_TKS   = 1024;

  typedef enum logic [1:0] {
    VBADT_MODE_OFF   = 2'h0,
    VBADT_MODE_SENSE = 2'h1,
    VBADT_MODE_PRB_A = 2'h2,
    VBADT_MODE_PRB_B = 2'h3
  } vbadt_mode_t;

  // Level comparator flags
  typedef struct packed {
    logic a_device_bus_valid_flag;
    logic b_session_valid_flag;
    logic a_session_valid_flag;
    logic b_session_end_flag;
    logic otg2_session_valid_flag;
  } vbadt_lvl_t;

  // Attach protocol settings
  typedef struct packed {
    vbadt_mode_t attach_protocol_mode;
    logic [7:0]  rise_time_low_limit;
    logic [7:0]  rise_time_high_limit;
  } vbadt_cfg_t;
endpackage : vbadt_pkg
`default_nettype wire

// file: vbadt_vbus_model.sv
// Purpose: Remote VBUS side: charge timing and sense pulses
// Assumes: Rise given in ticks; 9'h1FF never reaches threshold
// Notes:   Sense pulses stop while i_sns_run is low
`default_nettype none
module vbadt_vbus_model (
  // Clock
  input  wire logic       i_sys_clk,
  input  wire logic       i_tick,
  // Device drive
  input  wire logic       i_sink,
  input  wire logic       i_src,
  input  wire logic [8:0] i_rise,
  input  wire logic       i_sns_run,
  // Comparators
  output logic            o_prb,
  output logic            o_sns
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] chg_q = 9'h000;
  logic [3:0] sns_q = 4'h0;
  // Charge only while source on, discharge under sink
  always @(posedge i_sys_clk)
  begin
    if (i_sink)
      chg_q <= 9'h000;
    else if (i_src && i_tick && chg_q != 9'h1FE)
      chg_q <= chg_q + 9'h001;
    if (i_tick)
      sns_q <= sns_q + 4'h1;
  end
  assign o_prb = !i_sink && (chg_q >= i_rise);
  assign o_sns = i_sns_run && sns_q[3];
endmodule : vbadt_vbus_model
`default_nettype wire

// file: vbadt_top_bench.sv
// Purpose: Self-checking bench for vbadt_top
// Assumes: Crystal tick compressed to one pulse in 16 cycles
// Notes:   Probe results checked from a queue at each new discharge
`default_nettype none
module vbadt_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import vbadt_pkg::*;
  typedef struct packed {
    logic [8:0] n;
    logic       irq;
  } vbadt_exp_t;
  localparam int unsigned LVL = 8;
  localparam int unsigned SNS = 24;
  localparam int unsigned PER = 280;
  logic        clk = 1'b0, rst = 1'b1, tick = 1'b0, wk = 1'b0, ov = 1'b0;
  logic        son = 1'b1, otp = 1'b1, wr = 1'b0, wen = 1'b0, mask = 1'b0;
  logic        sns_run = 1'b0, sink_p = 1'b0, tick_p = 1'b0;
  logic [3:0]  tcnt = 4'h0;
  logic [8:0]  rise = 9'h1FF, rn;
  logic [31:0] lfsr = 32'h0000A3FE;
  logic [4:0]  r, p;
  vbadt_lvl_t  lvl = '0;
  vbadt_cfg_t  cfg = '0;
  logic        prb, sns, reg_en, sw, wirq, sink, src, airq;
  vbadt_lvl_t  ldeb, lirq;
  logic [7:0]  meas, lo, hi;
  vbadt_exp_t  exp_q[$];
  vbadt_exp_t  e;
  int          miscompares = 0, comparisons = 0, k, s;
  int          wk_n = 0, lv_n = 0, at_n = 0, at_s = 0;
  int          nsink = 0, per = 0, sink_c = 0, ovl = 0;

  vbadt_top #(.LVL_CYC(LVL), .ADP_CYC(3), .SNS_TKS(SNS), .PER_TKS(PER)) DUT (
    .i_sys_clk(clk), .i_reset(rst), .i_xtal_tick(tick), .i_vbus_wakeup_cmp(wk),
    .i_lvl(lvl), .i_probing_comparator(prb), .i_sensing_comparator(sns),
    .i_vbus_overvoltage(ov), .i_precharge(1'b0), .i_power_on_reset_out(1'b1),
    .i_system_on(son), .i_regulator_auto_control_disable(otp),
    .i_usb_regulator_state_reg_wr(wr), .i_usb_regulator_state_reg_en(wen),
    .i_wakeup_mask(mask), .i_cfg(cfg), .o_usb_regulator_en(reg_en),
    .o_charger_mid_node_switch_closed(sw), .o_wakeup_irq(wirq), .o_lvl_deb(ldeb),
    .o_lvl_irq(lirq), .o_probe_current_sink_en(sink), .o_probe_current_source_en(src),
    .o_measured_rise_time(meas), .o_rise_time_low_limit(lo),
    .o_rise_time_high_limit(hi), .o_attach_irq(airq));

  vbadt_vbus_model u_far (.i_sys_clk(clk), .i_tick(tick), .i_sink(sink), .i_src(src),
    .i_rise(rise), .i_sns_run(sns_run), .o_prb(prb), .o_sns(sns));

  always #5 clk = ~clk;

  always @(posedge clk)
  begin
    tcnt <= tcnt + 4'h1;
    tick <= (tcnt == 4'hF);
  end

  function automatic logic [31:0] nxt(input logic [31:0] v);
    nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt

  task automatic end_of_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask : chk

  task automatic chk_rng(input logic [7:0] got, input logic [8:0] n, input string m);
    logic [8:0] g;
    g = {1'b0, got};
    if (n == 9'h1FF)
      chk(got, 8'hFF, m);
    else
      chk((g === n) || (g + 9'd1 === n) || (g === n + 9'd1), 1'b1, m);
  endtask : chk_rng

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic wait_sink(input int n0);
    for (int i = 0; i < 6000 && nsink <= n0; i++)
      @(posedge clk);
    if (nsink <= n0)
    begin
      chk(0, 1, "timeout waiting for probe");
      end_of_test();
    end
  endtask : wait_sink

  task automatic probe(input vbadt_mode_t m, input logic [8:0] n, input logic [7:0] l,
                       input logic [7:0] h, input logic irq);
    cfg <= {m, l, h};
    rise <= n;
    wait_sink(nsink);
    wait_sink(nsink);
    exp_q.push_back({n, irq});
    chk(lo, l, "low limit copy");
    chk(hi, h, "high limit copy");
    wait_sink(nsink);
  endtask : probe

  // Monitor of irq counts and probe results
  always @(posedge clk)
  begin
    wk_n += int'(wirq);
    lv_n += $countones(lirq);
    at_n += int'(airq);
    per++;
    if (sink && !sink_p)
      sink_c = int'(tick_p);
    if (sink)
      sink_c += int'(tick);
    if (src && prb)
      ovl++;
    if (src && sink)
      chk(0, 1, "sink and source together");
    if (cfg.attach_protocol_mode == VBADT_MODE_OFF)
      nsink = 0;
    if (sink && !sink_p)
    begin
      if (nsink > 1)
        chk(per, PER * 16, "probe period");
      if (exp_q.size() > 0)
      begin
        e = exp_q.pop_front();
        chk_rng(meas, e.n, "rise time");
        chk(at_n != at_s, e.irq, "probe irq");
        chk(ovl < 12, 1'b1, "source off at threshold");
      end
      nsink++;
      per = 0;
      at_s = at_n;
      ovl = 0;
    end
    if (!sink && sink_p && cfg.attach_protocol_mode[1])
      chk(sink_c, SINK_TICKS, "sink length");
    if (!sink)
      sink_c = 0;
    sink_p = sink;
    tick_p = tick;
  end

  initial
  begin
    cyc(3);
    rst <= 1'b0;
    cyc(2);
    wk <= 1'b1;
    cyc(3);
    chk(reg_en, 1'b0, "auto follow while disabled");
    chk(wk_n, 1, "wake irq");
    rst <= 1'b1;
    otp <= 1'b0;
    mask <= 1'b1;
    cyc(3);
    rst <= 1'b0;
    cyc(3);
    chk(reg_en, 1'b1, "follow wake");
    son <= 1'b0;
    cyc(3);
    chk(reg_en, 1'b1, "system off");
    wk <= 1'b0;
    cyc(3);
    chk(reg_en, 1'b0, "follow wake low");
    chk(wk_n, 1, "masked wake");
    mask <= 1'b0;
    wk <= 1'b1;
    cyc(3);
    chk(wk_n, 2, "unmasked wake");
    {wr, wen} <= 2'b10;
    cyc(1);
    wr <= 1'b0;
    cyc(3);
    chk(reg_en, 1'b0, "write off");
    wk <= 1'b0;
    cyc(2);
    wk <= 1'b1;
    cyc(3);
    chk(reg_en, 1'b0, "no follow after write");
    {wr, wen} <= 2'b11;
    cyc(1);
    wr <= 1'b0;
    cyc(3);
    chk(reg_en, 1'b1, "write on");
    chk(sw, 1'b1, "switch closed");
    ov <= 1'b1;
    cyc(3);
    chk(sw, 1'b0, "switch open on overvoltage");
    {wr, wen} <= 2'b10;
    cyc(1);
    wr <= 1'b0;
    cyc(3);
    chk(reg_en, 1'b0, "host turns regulator off");
    ov <= 1'b0;
    p = 5'h00;
    for (k = 0; k < 4; k++)
    begin
      lfsr = nxt(lfsr);
      r = lfsr[4:0];
      s = lv_n;
      lvl <= r;
      cyc(LVL - 3);
      lvl <= p;
      cyc(LVL + 5);
      chk(ldeb, p, "glitch passed");
      lvl <= r;
      cyc(LVL + 5);
      chk(ldeb, r, "debounced level");
      chk(lv_n - s, $countones(r ^ p), "level irq count");
      p = r;
    end
    cfg <= {VBADT_MODE_OFF, 8'h55, 8'hAA};
    cyc(4);
    chk({lo, hi}, 16'h0000, "limits while off");
    lfsr = nxt(lfsr);
    rn = {3'b000, lfsr[13:8]} + 9'd20;
    probe(VBADT_MODE_PRB_A, rn, 8'h0A, 8'hC8, 1'b0);
    probe(VBADT_MODE_PRB_A, 9'd20, 8'h1E, 8'hC8, 1'b1);
    cfg <= {VBADT_MODE_OFF, 8'h55, 8'hAA};
    cyc(4);
    chk({meas, lo, hi}, 24'h000000, "cleared when off");
    probe(VBADT_MODE_PRB_B, 9'd80, 8'h0A, 8'h32, 1'b1);
    probe(VBADT_MODE_PRB_B, 9'h1FF, 8'h00, 8'hFF, 1'b0);
    cfg <= {VBADT_MODE_SENSE, 8'h00, 8'h00};
    sns_run <= 1'b1;
    cyc(16);
    s = at_n;
    cyc(1024);
    chk(at_n == s, 1'b1, "sense irq with activity");
    sns_run <= 1'b0;
    s = at_n;
    cyc(16 * (SNS + 20));
    chk(at_n > s, 1'b1, "sense timeout irq");
    end_of_test();
  end
endmodule : vbadt_top_bench
`default_nettype wire
